// file: src/pin_ctrl_defines.svh
// Constants for the control-pin logic of the clock generator.
// Assumes inclusion by bare name from files under src/.
`ifndef PIN_CTRL_DEFINES_SVH
`define PIN_CTRL_DEFINES_SVH

// Register offsets, byte addresses on the 8-bit address of the 32-bit register port.
`define REG_STATUS      8'h00
`define REG_OUT_DISABLE 8'h04
`define REG_OUT_STATE   8'h08
`define REG_ADDR_INFO   8'h0C
`define REG_DIV_BASE    8'h20
`define REG_DIV_STRIDE  8'h08
`define REG_DIV_B_OFS   8'h04

// Status register field positions.
`define ST_LOSS_BIT     0
`define ST_FAULT_BIT    1
`define ST_REF_LO       2
`define ST_SPREAD_LO    4
`define ST_FRAC_LO      6

// Integer divide value range and reset values.
`define DIV_MIN         8'h08
`define DIV_MAX         8'hFF
`define DIV_A_RESET     8'h08
`define DIV_B_RESET     8'h10

// Output enable timing, in output clock periods and microseconds.
`define OE_DISABLE_PERIODS 2'h3
`define OE_ENABLE_MAX_US   20
`define CLK_PERIOD_NS      10
`define OE_ENABLE_MAX_CYC  ((`OE_ENABLE_MAX_US * 1000) / `CLK_PERIOD_NS)

// Base serial bus target address, upper six bits; value is arbitrary.
`define TARGET_ADDR_BASE   6'h35

`endif

// file: src/pin_ctrl_pkg.sv
// Types shared by the control-pin logic.
// Assumes nothing beyond a SystemVerilog compiler.
package pin_ctrl_pkg;

  // Reach of one output-enable pin.
  typedef enum logic [1:0] {
    OE_NONE   = 2'b00,
    OE_SINGLE = 2'b01,
    OE_BANK   = 2'b10,
    OE_ALL    = 2'b11
  } oe_scope_t;

  // Reference sources reached by the two-bit source select.
  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'b00,
    SRC_INPUT_B = 2'b01,
    SRC_INPUT_C = 2'b10,
    SRC_RSVD    = 2'b11
  } ref_src_t;

endpackage

// file: src/config_control_pin_logic.sv
// Control logic behind the user-assignable control pins of a clock
// generator: spread and frequency selects, output enables, address
// select, source select and the fault indicators.
// Assumes all pins arrive as plain inputs and one 100 MHz clock mclk.
// Assumes the host never raises both register strobes together.
`timescale 1ns/10ps
`include "pin_ctrl_defines.svh"

// Function
// - Each spread enable pin turns modulation off low, on high.
// - Spread and frequency-select changes act at once, glitches possible.
// - Five integer dividers, one per bank, each with own select pin.
// - Integer select low picks preset A, high picks preset B.
// - Each preset divide value lies in 8 to 255 inclusive.
// - An enable pin reaches one output, one bank, or all outputs.
// - Deasserting enable stops each output within 2 to 6 periods.
// - Reenabling yields a clean clock within 20 microseconds.
// - True and complement single-ended pair enable and disable together.
// - Disable and enable reach a defined state without glitches.
// - Address pin sets the low bit of the 7-bit target address.
// - Two-bit source select picks crystal or one clock input.
// - Loss flag asserts when selected reference is slow or missing.
// - Loss flag is active low open drain.
// - Tracking fault asserts whenever the PLL cannot follow reference.
// - Register port serves as the serial bus target interface.
// - Bus writes change volatile settings only, lost at power down.
// - Pin function assignments cannot be changed by bus writes.
// - Stored configuration produces clocks at power up unaided.
// - Loss flag is absent on generic volatile-only parts.
// - Disable finishes current period; enable aligns to period start.
// - Enabled outputs may still be disabled by register bits.
module config_control_pin_logic
  import pin_ctrl_pkg::*;
#(
  parameter int          NUM_OUT  = 6,
  parameter int          NUM_OE   = 2,
  parameter logic [17:0] OUT_BANK = 18'h0A418,
  parameter logic [3:0]  OE_SCOPE = 4'b1001,
  parameter logic [7:0]  OE_TGT   = 8'h20,
  parameter logic [4:0]  FS_USED  = 5'h1F,
  parameter bit          LOSS_FEATURE = 1'b1
) (
  // Clock, reset and clock enable.
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Register port.
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // Control pins.
  input  wire logic [1:0]         spread_enable_inputs,
  input  wire logic [4:0]         int_divider_freq_select,
  input  wire logic [1:0]         frac_divider_freq_select,
  input  wire logic [NUM_OE-1:0]  out_enable_n,
  input  wire logic               addr_select,
  input  wire logic [1:0]         input_source_select,
  // Reference monitor and PLL status.
  input  wire logic [2:0]         ref_detected,
  input  wire logic [2:0]         ref_freq_low,
  input  wire logic               pll_unlock,
  // Controls to the synthesis core.
  output logic [1:0]              spread_on,
  output logic [1:0]              frac_profile_sel,
  output logic [1:0]              ref_select,
  output logic [6:0]              target_addr,
  // Output buffers, true and complement.
  output logic [NUM_OUT-1:0]      clk_out_true,
  output logic [NUM_OUT-1:0]      clk_out_comp,
  // Indicators.
  output logic                    reference_missing_flag_o,
  output logic                    reference_missing_flag_oe,
  output logic                    pll_tracking_fault
);

  // Pin map inside the synchronizer word, low bit first:
  //   [1:0]   spread enables, one per fractional synthesizer,
  //   [6:2]   integer divider selects, one per bank,
  //   [8:7]   fractional divider selects,
  //   [9]     address select,
  //   [11:10] source select,
  //   and the output enable pins above them.
  // One word gives every pin the same stage count, so pins that change
  // together also act together.
  localparam int NSYNC = NUM_OE + 12;

  // Synchronizer stages; stage one feeds stage two only.
  logic [NSYNC-1:0] pin_meta_r;
  logic [NSYNC-1:0] pin_sync_r;
  logic [NSYNC-1:0] pin_raw;

  // Synchronized pins split back into their functions.
  logic [1:0]        ss_s;
  logic [4:0]        fsi_s;
  logic [1:0]        fsf_s;
  logic [NUM_OE-1:0] oe_n_s;
  logic              adr_s;
  logic [1:0]        src_s;

  // Volatile registers. Nothing here survives power loss: reset brings
  // back the presets, which stand in for the stored configuration.
  logic [NUM_OUT-1:0] disable_r;
  logic [7:0]         div_a_r [5];
  logic [7:0]         div_b_r [5];

  // Divider state per bank.
  // A bank_edge bit marks the last cycle of a period, before the wrap.
  logic [4:0] bank_clk_r;
  logic [4:0] bank_edge;

  // Output gating state.
  logic [NUM_OUT-1:0] en_r;
  logic [NUM_OUT-1:0] want_en;
  logic               loss_now;

  // Gather the pins into one word, then split the second stage back
  // into its groups; the slices follow the map above.
  assign pin_raw = {out_enable_n, input_source_select, addr_select,
                    frac_divider_freq_select, int_divider_freq_select,
                    spread_enable_inputs};
  assign ss_s   = pin_sync_r[1:0];
  assign fsi_s  = pin_sync_r[6:2];
  assign fsf_s  = pin_sync_r[8:7];
  assign adr_s  = pin_sync_r[9];
  assign src_s  = pin_sync_r[11:10];
  assign oe_n_s = pin_sync_r[NSYNC-1:12];

  // Two flops per pin; nothing downstream looks at the first stage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Reset to the idle level of every pin, enabled and unspread, so
      // that the release of reset shows no false change on any pin.
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else if (ce) begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Pin-driven controls for the synthesis core act on the next edge.
  // They reach the core ungated, so a change may disturb the outputs
  // it affects; a user who needs clean edges must disable them first.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spread_on        <= 2'h0;
      frac_profile_sel <= 2'h0;
      target_addr      <= {`TARGET_ADDR_BASE, 1'b0};
    end else if (ce) begin
      spread_on        <= ss_s;
      frac_profile_sel <= fsf_s;
      target_addr      <= {`TARGET_ADDR_BASE, adr_s};
    end
  end

  // Source select; the reserved code keeps the previous choice because
  // switching to nothing would only add one more disturbance.
  // Switching is not glitch free; receivers must tolerate it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_select <= SRC_CRYSTAL;
    end else if (ce && src_s != SRC_RSVD) begin
      ref_select <= src_s;
    end
  end

  // Loss of the selected reference, slow or gone.
  // The reserved code never reaches ref_select, but if it did the
  // missing choice would count as a loss, which errs on the safe side.
  always_comb begin
    loss_now = 1'b0;
    case (ref_select)
      SRC_CRYSTAL: loss_now = ~ref_detected[0] | ref_freq_low[0];
      SRC_INPUT_B: loss_now = ~ref_detected[1] | ref_freq_low[1];
      SRC_INPUT_C: loss_now = ~ref_detected[2] | ref_freq_low[2];
      default:     loss_now = 1'b1;
    endcase
  end

  // Indicators; the loss pin only ever pulls low or floats.
  // The open-drain pin is data fixed low plus an enable. The fault
  // output also follows the loss term, since a PLL with no reference
  // cannot track it even before its own detector notices.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reference_missing_flag_o  <= 1'b0;
      reference_missing_flag_oe <= 1'b0;
      pll_tracking_fault        <= 1'b0;
    end else if (ce) begin
      reference_missing_flag_o  <= 1'b0;
      reference_missing_flag_oe <= LOSS_FEATURE & loss_now;
      pll_tracking_fault        <= pll_unlock | loss_now;
    end
  end

  // Register writes. Pin assignments live in parameters, not here, so
  // the bus cannot move a pin to another function. Nothing is stored
  // beyond these flops; reset brings back the factory presets.
  // Limitation: a refused divide value is dropped silently, so software
  // must read it back to learn whether it took.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      disable_r <= '0;
      for (int k = 0; k < 5; k++) begin
        div_a_r[k] <= `DIV_A_RESET;
        div_b_r[k] <= `DIV_B_RESET;
      end
    end else if (ce && reg_wr) begin
      if (reg_addr == `REG_OUT_DISABLE) begin
        disable_r <= reg_wdata[NUM_OUT-1:0];
      end
      for (int k = 0; k < 5; k++) begin
        // One loop decodes all five dividers so their maps cannot drift.
        // Values below the minimum are refused and the old one stays.
        if (reg_wdata[7:0] >= `DIV_MIN && reg_wdata[31:8] == 24'h0) begin
          if (reg_addr == `REG_DIV_BASE + 8'(k) * `REG_DIV_STRIDE) begin
            div_a_r[k] <= reg_wdata[7:0];
          end
          if (reg_addr == `REG_DIV_BASE + 8'(k) * `REG_DIV_STRIDE
                          + `REG_DIV_B_OFS) begin
            div_b_r[k] <= reg_wdata[7:0];
          end
        end
      end
    end
  end

  // Register reads; data stand in the cycle after the strobe only.
  // Reads have no side effects, and the data fall back to zero after
  // their cycle so that a late sample never shows stale data.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `REG_STATUS: begin
            reg_rdata[`ST_LOSS_BIT]                <= loss_now;
            reg_rdata[`ST_FAULT_BIT]               <= pll_tracking_fault;
            reg_rdata[`ST_REF_LO+1:`ST_REF_LO]     <= ref_select;
            reg_rdata[`ST_SPREAD_LO+1:`ST_SPREAD_LO] <= spread_on;
            reg_rdata[`ST_FRAC_LO+1:`ST_FRAC_LO]   <= frac_profile_sel;
          end
          `REG_OUT_DISABLE: reg_rdata[NUM_OUT-1:0] <= disable_r;
          `REG_OUT_STATE:   reg_rdata[NUM_OUT-1:0] <= en_r;
          `REG_ADDR_INFO:   reg_rdata[6:0]         <= target_addr;
          default: begin
            for (int k = 0; k < 5; k++) begin
              if (reg_addr == `REG_DIV_BASE + 8'(k) * `REG_DIV_STRIDE) begin
                reg_rdata[7:0] <= div_a_r[k];
              end
              if (reg_addr == `REG_DIV_BASE + 8'(k) * `REG_DIV_STRIDE
                              + `REG_DIV_B_OFS) begin
                reg_rdata[7:0] <= div_b_r[k];
              end
            end
          end
        endcase
      end
    end
  end

  // One integer divider per bank. A select change takes the new value
  // at once; the counter wraps early rather than running past the end,
  // which may shorten one period.
  // The trade: the live select is compared, not a value latched at the
  // wrap, which is what makes the select act at once.
  for (genvar b = 0; b < 5; b++) begin : g_div
    logic [7:0] cnt_r;
    logic [7:0] div_val;
    logic [7:0] cnt_nxt;

    always_comb begin
      div_val = (FS_USED[b] && fsi_s[b]) ? div_b_r[b]
                                         : div_a_r[b];
      if (cnt_r >= div_val - 8'h01) begin
        cnt_nxt = 8'h00;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end

    // Period starts when the counter wraps; the clock is high first.
    assign bank_edge[b] = (cnt_nxt == 8'h00);

    // Counter and bank clock advance together, so the rise of the clock
    // lands on the edge that ends a boundary cycle, except when a select change raises the divide value mid-period.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cnt_r         <= 8'h00;
        bank_clk_r[b] <= 1'b0;
      end else if (ce) begin
        cnt_r         <= cnt_nxt;
        bank_clk_r[b] <= cnt_nxt < (div_val >> 1);
      end
    end
  end

  // Per output: gather the enable pins that reach it, then gate its
  // bank clock only at period boundaries.
  // The register bit or any pin whose reach covers the output can stop
  // it on its own.
  for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
    localparam logic [2:0] BANK = OUT_BANK[3*o +: 3];
    logic [1:0] wait_r;

    always_comb begin
      want_en[o] = ~disable_r[o];
      for (int p = 0; p < NUM_OE; p++) begin
        case (oe_scope_t'(OE_SCOPE[2*p +: 2]))
          OE_SINGLE: if (OE_TGT[4*p +: 4] == 4'(o) && oe_n_s[p])
                       want_en[o] = 1'b0;
          OE_BANK:   if (OE_TGT[4*p +: 3] == BANK && oe_n_s[p])
                       want_en[o] = 1'b0;
          OE_ALL:    if (oe_n_s[p]) want_en[o] = 1'b0;
          default:   ;
        endcase
      end
    end

    // Disable waits for the third boundary, so the output stops after
    // two to three whole periods; enable starts at the next boundary,
    // at most 255 cycles away, far inside the enable limit.
    // A pin that returns before the disable lands cancels it, since
    // the wait count clears whenever the request goes away.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        en_r[o] <= 1'b1;
        wait_r  <= 2'h0;
      end else if (ce) begin
        if (en_r[o] && !want_en[o]) begin
          if (bank_edge[BANK]) begin
            if (wait_r == `OE_DISABLE_PERIODS - 2'h1) begin
              en_r[o] <= 1'b0;
              wait_r  <= 2'h0;
            end else begin
              wait_r <= wait_r + 2'h1;
            end
          end
        end else if (!en_r[o] && want_en[o] && bank_edge[BANK]) begin
          en_r[o] <= 1'b1;
          wait_r  <= 2'h0;
        end else begin
          wait_r <= 2'h0;
        end
      end
    end

    // Both pins of the pair share one gate and rest low when off.
    // The gate only moves at a boundary, where the bank clock rises, so
    // neither pin shows a partial phase; both rest low, a known state.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        clk_out_true[o] <= 1'b0;
        clk_out_comp[o] <= 1'b0;
      end else if (ce) begin
        clk_out_true[o] <= en_r[o] & bank_clk_r[BANK];
        clk_out_comp[o] <= en_r[o] & ~bank_clk_r[BANK];
      end
    end
  end

endmodule

// file: sim/pin_ctrl_asserts.sv
// Port checker for the control-pin logic.
// Assumes pins held low during reset; ce low restarts the warm-up count.
`timescale 1ns/10ps
`include "pin_ctrl_defines.svh"
module pin_ctrl_asserts #(
  parameter int NUM_OUT      = 6,
  parameter bit LOSS_FEATURE = 1'b1
) (
  // Clock and reset.
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               ce,
  // Pins and monitor inputs.
  input wire logic               reg_rd,
  input wire logic [1:0]         spread_enable_inputs,
  input wire logic [1:0]         frac_divider_freq_select,
  input wire logic               addr_select,
  input wire logic [1:0]         input_source_select,
  input wire logic [2:0]         ref_detected,
  input wire logic [2:0]         ref_freq_low,
  input wire logic               pll_unlock,
  // Outputs watched.
  input wire logic [31:0]        reg_rdata,
  input wire logic [1:0]         spread_on,
  input wire logic [1:0]         frac_profile_sel,
  input wire logic [1:0]         ref_select,
  input wire logic [6:0]         target_addr,
  input wire logic [NUM_OUT-1:0] clk_out_true,
  input wire logic [NUM_OUT-1:0] clk_out_comp,
  input wire logic               reference_missing_flag_o,
  input wire logic               reference_missing_flag_oe,
  input wire logic               pll_tracking_fault
);
  logic [1:0] up_r;
  wire logic  loss_now = LOSS_FEATURE &&
    (!ref_detected[ref_select] || ref_freq_low[ref_select]);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Edges since reset or a frozen spell, so that the $past checks gated
  // on this count never reach back into a cycle in which the design did not advance.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      up_r <= 2'h0;
    end else if (!ce) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end

  a_spread_follow: assert property (up_r == 2'h3 |->
    spread_on == $past(spread_enable_inputs, 3)) else $error("spread lag");
  a_frac_follow: assert property (up_r == 2'h3 |->
    frac_profile_sel == $past(frac_divider_freq_select, 3))
    else $error("profile lag");
  a_addr_low_bit: assert property (up_r == 2'h3 |->
    target_addr == {`TARGET_ADDR_BASE, $past(addr_select, 3)})
    else $error("address low bit");
  a_source_pick: assert property (up_r == 2'h3 &&
    $past(input_source_select, 3) != 2'h3 |->
    ref_select == $past(input_source_select, 3)) else $error("source");
  a_loss_cause: assert property (up_r != 2'h0 |->
    reference_missing_flag_oe == $past(loss_now)) else $error("loss");
  a_loss_drain: assert property (!reference_missing_flag_o)
    else $error("loss drives high");
  a_fault_unlock: assert property (up_r != 2'h0 &&
    $past(pll_unlock) |-> pll_tracking_fault) else $error("fault");
  a_pair_gate: assert property (
    (clk_out_true & clk_out_comp) == '0) else $error("pair overlap");
  a_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");

  c_fault: cover property (pll_tracking_fault);
  c_loss: cover property (reference_missing_flag_oe);
  c_clock: cover property ($rose(clk_out_true[0]));
endmodule

bind config_control_pin_logic pin_ctrl_asserts #(
  .NUM_OUT(NUM_OUT), .LOSS_FEATURE(LOSS_FEATURE)) i_chk (
  .mclk, .rst, .ce, .reg_rd, .spread_enable_inputs,
  .frac_divider_freq_select,
  .addr_select, .input_source_select, .ref_detected, .ref_freq_low,
  .pll_unlock, .reg_rdata, .spread_on, .frac_profile_sel, .ref_select,
  .target_addr, .clk_out_true, .clk_out_comp, .reference_missing_flag_o,
  .reference_missing_flag_oe, .pll_tracking_fault);

// file: sim/safety_mgr_model.sv
// Safety-manager model driving the source select pins.
// Assumes the bench names the wanted primary source.
`timescale 1ns/10ps
module safety_mgr_model
  import pin_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst,
  // Request, fault and pins.
  input  wire logic [1:0] want_src,
  input  wire logic       fault,
  output logic      [1:0] src_sel
);
  logic failed_r;

  // Select changes only on a request or on a fault; the fallback is
  // latched so a cleared fault cannot bounce back to a dead source.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_sel  <= SRC_CRYSTAL;
      failed_r <= 1'b0;
    end else begin
      if (fault) failed_r <= 1'b1;
      else if (want_src != SRC_CRYSTAL) failed_r <= 1'b0;
      src_sel <= (fault || failed_r) ? SRC_INPUT_B : want_src;
    end
  end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the control-pin logic.
// Assumes the design's default parameters.
`timescale 1ns/10ps
`include "pin_ctrl_defines.svh"
module tb_top;
  import pin_ctrl_pkg::*;
  logic        mclk, rst, ce, reg_wr, reg_rd, addr_select, pll_unlock;
  logic        reference_missing_flag_o, reference_missing_flag_oe;
  logic        pll_tracking_fault;
  logic [7:0]  reg_addr, a, va, vb, b0;
  logic [31:0] reg_wdata, reg_rdata, d, s;
  logic [1:0]  spread_enable_inputs, frac_divider_freq_select, exp_src;
  logic [1:0]  out_enable_n, input_source_select, want_src;
  logic [1:0]  spread_on, frac_profile_sel, ref_select;
  logic [4:0]  int_divider_freq_select;
  logic [2:0]  ref_detected, ref_freq_low;
  logic [6:0]  target_addr;
  logic [5:0]  clk_out_true, clk_out_comp, seen;
  int          n_mismatch, comparisons, p;

  config_control_pin_logic i_dut (.mclk, .rst, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .spread_enable_inputs,
    .int_divider_freq_select, .frac_divider_freq_select, .out_enable_n,
    .addr_select, .input_source_select, .ref_detected, .ref_freq_low,
    .pll_unlock, .spread_on, .frac_profile_sel, .ref_select, .target_addr,
    .clk_out_true, .clk_out_comp, .reference_missing_flag_o,
    .reference_missing_flag_oe, .pll_tracking_fault);
  safety_mgr_model i_mgr (.mclk, .rst, .want_src, .fault(pll_tracking_fault),
    .src_sel(input_source_select));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Watchdog: the whole run needs well under 50 us.
  initial begin
    #200us;
    n_mismatch++;
    close_out();
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    dt = reg_rdata;
  endtask

  task automatic step(inout int n);
    @(posedge mclk);
    #1;
    n++;
  endtask

  // Cycles between two rising edges of output 0, bounded.
  task automatic period(output int n);
    repeat (2) begin
      n = 0;
      while (clk_out_true[0] === 1'b1 && n < 600) step(n);
      while (clk_out_true[0] !== 1'b1 && n < 600) step(n);
    end
  endtask

  // Collects any high level on the outputs selected by m over a span.
  task automatic watch(input int n, input logic [5:0] m);
    seen = '0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      seen |= (clk_out_true | clk_out_comp) & m;
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    {rst, ce, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 42'h0};
    {spread_enable_inputs, frac_divider_freq_select, addr_select} = '0;
    {int_divider_freq_select, out_enable_n, want_src, pll_unlock} = '0;
    ref_detected = 3'h7;
    ref_freq_low = 3'h0;
    void'($urandom(32'hF79E));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(`REG_DIV_BASE, d);
    chk("div_a_reset", `DIV_A_RESET, d);
    rd(`REG_DIV_BASE + `REG_DIV_B_OFS, d);
    chk("div_b_reset", `DIV_B_RESET, d);
    rd(8'hFC, d);
    chk("unmapped", 32'h0, d);
    // Boundary and random divide values; out-of-range writes refused.
    for (int k = 0; k < 5; k++) begin
      a = `REG_DIV_BASE + 8'(k) * `REG_DIV_STRIDE;
      va = (k == 1) ? `DIV_MAX : `DIV_MIN + 8'((k > 1) * $urandom_range(8));
      vb = `DIV_MIN + 8'($urandom_range(1, 12));
      if (k == 0) b0 = vb;
      wr(a, {24'h0, va});
      wr(a + `REG_DIV_B_OFS, {24'h0, vb});
      wr(a, 32'h7);
      wr(a + `REG_DIV_B_OFS, {24'h1, vb});
      rd(a, d);
      chk("div_a", {24'h0, va}, d);
      rd(a + `REG_DIV_B_OFS, d);
      chk("div_b", {24'h0, vb}, d);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      int_divider_freq_select <= {4'($urandom), k[0]};
      repeat (4) @(posedge mclk);
      #1;
      period(p);
      chk("period", k ? b0 : `DIV_MIN, p);
    end
    // Random pin levels, every source code included.
    exp_src = SRC_CRYSTAL;
    for (int k = 0; k < 8; k++) begin
      s = $urandom;
      if (k < 4) s[6:5] = 2'(k);
      if (s[6:5] != 2'h3) exp_src = s[6:5];
      @(posedge mclk);
      spread_enable_inputs <= s[1:0];
      frac_divider_freq_select <= s[3:2];
      addr_select <= s[4];
      want_src <= s[6:5];
      repeat (6) @(posedge mclk);
      #1;
      chk("target_addr", {`TARGET_ADDR_BASE, s[4]}, target_addr);
      rd(`REG_STATUS, d);
      chk("status", {24'h0, s[3:0], exp_src, 2'b00},
          d);
    end
    // Primary reference lost, manager falls back.
    @(posedge mclk);
    want_src <= SRC_CRYSTAL;
    repeat (6) @(posedge mclk);
    ref_detected <= 3'b110;
    @(posedge mclk);
    #1;
    chk("loss_flag", 1, reference_missing_flag_oe);
    chk("fault", 1, pll_tracking_fault);
    repeat (10) @(posedge mclk);
    #1;
    chk("fallback", SRC_INPUT_B, ref_select);
    chk("loss_clear", 0, reference_missing_flag_oe);
    @(posedge mclk);
    {want_src, ref_detected, ref_freq_low} <= {SRC_INPUT_B, 6'b111010};
    pll_unlock <= 1'b1;
    @(posedge mclk);
    #1;
    chk("slow_ref", 1, reference_missing_flag_oe);
    @(posedge mclk);
    {ref_freq_low, pll_unlock} <= 4'h0;
    // Register disable of all, then re-enable in time.
    wr(`REG_OUT_DISABLE, 32'h3F);
    watch(800, 6'h00);
    watch(16, 6'h3F);
    chk("reg_disable", 0, seen);
    wr(`REG_OUT_DISABLE, 32'h0);
    watch(`OE_ENABLE_MAX_CYC, 6'h3F);
    chk("reenable", 6'h3F, seen);
    // Pin 0 reaches output 0, pin 1 the outputs of bank 2.
    @(posedge mclk);
    out_enable_n <= 2'b11;
    watch(100, 6'h00);
    watch(40, 6'h19);
    chk("pin_disable", 0, seen);
    // Clock enable low freezes every output where it stands.
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    #1;
    s = {26'h0, clk_out_true};
    seen = '0;
    repeat (30) begin
      @(posedge mclk);
      #1;
      seen |= clk_out_true ^ s[5:0];
    end
    chk("ce_freeze", 0, seen);
    @(posedge mclk);
    ce <= 1'b1;
    close_out();
  end
endmodule
